// ### pfmd_map.svh
// Constants of the paper-feed motor drive block: input encodings, phase order.
// Assumes one 40 MHz clock, all command inputs arriving asynchronously from pins.
`ifndef PFMD_MAP_SVH
`define PFMD_MAP_SVH
// ************************************************************
// Command encodings {a,b}
// ************************************************************
`define PFMD_CMD_OFF    2'b00
`define PFMD_CMD_LH     2'b01
`define PFMD_CMD_HL     2'b10
`define PFMD_CMD_BRAKE  2'b11
// ************************************************************
// Transport phase pattern, two-phase-on, one step per reference clock rise
// ************************************************************
`define PFMD_PHASE_RESET 4'h3
`define PFMD_SYNC_STAGES 2
// Synchroniser reset: on and enable inputs read inactive (high)
`define PFMD_SYNC_RESET  18'h00240
`endif

// ### pfmd_pkg.sv
// Types shared by the paper-feed motor drive block.
// Assumes the constants header is included by the user of each type.
package pfmd_pkg;
   typedef struct packed {
      logic a;
      logic b;
   } pfmd_bridge_t;
   typedef struct packed {
      logic a_o;
      logic b_o;
      logic a_oe;
      logic b_oe;
   } pfmd_drive_t;
   typedef enum logic [1:0] {
      PFMD_MODE_RAMP  = 2'b01,
      PFMD_MODE_CONST = 2'b10
   } pfmd_speed_t;
endpackage

// ### pfmd_drive.sv
// Paper-feed motor drive: lift/fence H-bridges, feed motor gate, transport and
// registration stepping drivers. Inputs are pins, so all pass two flip-flops.
`timescale 1ns/1ps
`include "pfmd_map.svh"
module pfmd_drive #(
   parameter int SYNC_STAGES = `PFMD_SYNC_STAGES
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 upper_lift_dir_a_cmd,
   input  wire logic                 upper_lift_dir_b_cmd,
   input  wire logic                 lower_lift_dir_a_cmd,
   input  wire logic                 lower_lift_dir_b_cmd,
   input  wire logic                 lcf_lift_dir_a_cmd,
   input  wire logic                 lcf_lift_dir_b_cmd,
   input  wire logic                 fence_dir_a_cmd,
   input  wire logic                 fence_dir_b_cmd,
   input  wire logic                 feed_motor_on_n,
   input  wire logic                 feed_motor_ref_clock,
   input  wire logic                 transport_ref_clock,
   input  wire logic                 transport_enable_n,
   input  wire logic                 transport_speed_mode,
   input  wire logic                 registration_phase_a,
   input  wire logic                 registration_phase_b,
   input  wire logic                 registration_phase_c,
   input  wire logic                 registration_phase_d,
   input  wire logic                 registration_speed_mode,
   output pfmd_pkg::pfmd_drive_t     upper_lift_drive,
   output pfmd_pkg::pfmd_drive_t     lower_lift_drive,
   output pfmd_pkg::pfmd_drive_t     lcf_lift_drive,
   output pfmd_pkg::pfmd_drive_t     fence_drive,
   output logic                      feed_motor_drive,
   output logic                      transport_phase_a,
   output logic                      transport_phase_b,
   output logic                      transport_phase_a_bar,
   output logic                      transport_phase_b_bar,
   output pfmd_pkg::pfmd_speed_t     transport_speed,
   output logic [3:0]                registration_drive,
   output pfmd_pkg::pfmd_speed_t     registration_speed
);
   localparam int NIN = 18;

   if (SYNC_STAGES != 2) begin : g_sync_check
      $error("SYNC_STAGES must be 2");
   end

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] meta_reg;
   logic [NIN-1:0] sync_reg;
   assign raw_in = {upper_lift_dir_a_cmd, upper_lift_dir_b_cmd, lower_lift_dir_a_cmd, lower_lift_dir_b_cmd,
                    lcf_lift_dir_a_cmd, lcf_lift_dir_b_cmd, fence_dir_a_cmd, fence_dir_b_cmd,
                    feed_motor_on_n, feed_motor_ref_clock, transport_ref_clock, transport_enable_n,
                    transport_speed_mode, registration_phase_a, registration_phase_b,
                    registration_phase_c, registration_phase_d, registration_speed_mode};

   // Off/safe levels at reset: enables and on inputs read inactive
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= `PFMD_SYNC_RESET;
         sync_reg <= `PFMD_SYNC_RESET;
      end else begin
         meta_reg <= raw_in;
         sync_reg <= meta_reg;
      end
   end

   wire [1:0] s_upper = sync_reg[17:16];
   wire [1:0] s_lower = sync_reg[15:14];
   wire [1:0] s_lcf   = sync_reg[13:12];
   wire [1:0] s_fence = sync_reg[11:10];
   wire       s_fm_on_n  = sync_reg[9];
   wire       s_fm_clk   = sync_reg[8];
   wire       s_tr_clk   = sync_reg[7];
   wire       s_tr_en_n  = sync_reg[6];
   wire       s_tr_mode  = sync_reg[5];
   wire [3:0] s_reg_ph   = sync_reg[4:1];
   wire       s_reg_mode = sync_reg[0];

   // ************************************************************
   // H-bridge decode
   // ************************************************************
   // One pin pattern serves both families; only the rotation name differs
   function automatic pfmd_pkg::pfmd_drive_t bridge(input logic [1:0] cmd);
      pfmd_pkg::pfmd_drive_t d;
      d = '0;
      unique case (cmd)
         `PFMD_CMD_OFF:   d = '{a_o: 1'b0, b_o: 1'b0, a_oe: 1'b0, b_oe: 1'b0};
         `PFMD_CMD_LH:    d = '{a_o: 1'b0, b_o: 1'b1, a_oe: 1'b1, b_oe: 1'b1};
         `PFMD_CMD_HL:    d = '{a_o: 1'b1, b_o: 1'b0, a_oe: 1'b1, b_oe: 1'b1};
         `PFMD_CMD_BRAKE: d = '{a_o: 1'b0, b_o: 1'b0, a_oe: 1'b1, b_oe: 1'b1};
      endcase
      return d;
   endfunction

   // Drawer lift: LH forward, HL reverse
   // drawer lift bridges
   wire pfmd_pkg::pfmd_drive_t upper_next = bridge(s_upper);
   wire pfmd_pkg::pfmd_drive_t lower_next = bridge(s_lower);
   // Feeder lift/fence: LH reverse, HL forward, same pin pattern
   // feeder lift and fence bridges
   wire pfmd_pkg::pfmd_drive_t lcf_next   = bridge(s_lcf);
   wire pfmd_pkg::pfmd_drive_t fence_next = bridge(s_fence);

   // ************************************************************
   // Feed motor
   // ************************************************************
   // drive only while on is low
   wire feed_next = ~s_fm_on_n & s_fm_clk;

   // ************************************************************
   // Transport stepper
   // ************************************************************
   logic       tr_clk_d_reg;
   logic [3:0] tr_phase_reg;
   wire        tr_step = s_tr_clk & ~tr_clk_d_reg;
   // step on each reference clock rise
   // step only while enable is low
   wire [3:0]  tr_phase_next = (tr_step && !s_tr_en_n) ? {tr_phase_reg[2:0], tr_phase_reg[3]} : tr_phase_reg;
   wire pfmd_pkg::pfmd_speed_t tr_speed_next = s_tr_mode ? pfmd_pkg::PFMD_MODE_CONST : pfmd_pkg::PFMD_MODE_RAMP;
   wire pfmd_pkg::pfmd_speed_t rg_speed_next = s_reg_mode ? pfmd_pkg::PFMD_MODE_CONST : pfmd_pkg::PFMD_MODE_RAMP;

   // ************************************************************
   // Output registers
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         upper_lift_drive      <= '0;
         lower_lift_drive      <= '0;
         lcf_lift_drive        <= '0;
         fence_drive           <= '0;
         feed_motor_drive      <= 1'b0;
         tr_clk_d_reg          <= 1'b0;
         tr_phase_reg          <= `PFMD_PHASE_RESET;
         transport_phase_a     <= 1'b0;
         transport_phase_b     <= 1'b0;
         transport_phase_a_bar <= 1'b0;
         transport_phase_b_bar <= 1'b0;
         transport_speed       <= pfmd_pkg::PFMD_MODE_RAMP;
         registration_drive    <= 4'h0;
         registration_speed    <= pfmd_pkg::PFMD_MODE_RAMP;
      end else begin
         upper_lift_drive      <= upper_next;
         lower_lift_drive      <= lower_next;
         lcf_lift_drive        <= lcf_next;
         fence_drive           <= fence_next;
         feed_motor_drive      <= feed_next;
         tr_clk_d_reg          <= s_tr_clk;
         tr_phase_reg          <= tr_phase_next;
         // Phases held low while disabled so the windings carry no current
         transport_phase_a     <= tr_phase_next[0] & ~s_tr_en_n;
         transport_phase_b     <= tr_phase_next[1] & ~s_tr_en_n;
         transport_phase_a_bar <= tr_phase_next[2] & ~s_tr_en_n;
         transport_phase_b_bar <= tr_phase_next[3] & ~s_tr_en_n;
         transport_speed       <= tr_speed_next;
         registration_drive    <= s_reg_ph;
         registration_speed    <= rg_speed_next;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   bridge_brake_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_upper == `PFMD_CMD_BRAKE) |=> (upper_lift_drive.a_oe && !upper_lift_drive.a_o && !upper_lift_drive.b_o))
      else $error("brake not driven low");
   bridge_off_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_fence == `PFMD_CMD_OFF) |=> (!fence_drive.a_oe && !fence_drive.b_oe))
      else $error("fence not released when off");
   feed_gate_a : assert property (@(posedge ref_clk) disable iff (rst)
      s_fm_on_n |=> !feed_motor_drive)
      else $error("feed motor driven while off");
   feed_follow_a : assert property (@(posedge ref_clk) disable iff (rst)
      (!s_fm_on_n && $rose(s_fm_clk)) |=> feed_motor_drive)
      else $error("feed drive not following clock");
   tr_step_a : assert property (@(posedge ref_clk) disable iff (rst)
      (tr_step && !s_tr_en_n) |=> (tr_phase_reg == {$past(tr_phase_reg[2:0]), $past(tr_phase_reg[3])}))
      else $error("transport phase did not advance");
   tr_hold_a : assert property (@(posedge ref_clk) disable iff (rst)
      s_tr_en_n |=> (!transport_phase_a && !transport_phase_b && $stable(tr_phase_reg)))
      else $error("transport pulses while disabled");
   tr_mode_a : assert property (@(posedge ref_clk) disable iff (rst)
      s_tr_mode |=> (transport_speed == pfmd_pkg::PFMD_MODE_CONST))
      else $error("transport speed mode wrong");
   reg_copy_a : assert property (@(posedge ref_clk) disable iff (rst)
      ##1 (registration_drive == $past(s_reg_ph)))
      else $error("registration phase not copied");
   reg_mode_a : assert property (@(posedge ref_clk) disable iff (rst)
      !s_reg_mode |=> (registration_speed == pfmd_pkg::PFMD_MODE_RAMP))
      else $error("registration speed mode wrong");
   bridge_fwd_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_upper == `PFMD_CMD_LH) |=> (upper_lift_drive == 4'h7))
      else $error("upper lift forward pattern wrong");
   lower_rev_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_lower == `PFMD_CMD_HL) |=> (lower_lift_drive == 4'hb))
      else $error("lower lift reverse pattern wrong");
   lower_off_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_lower == `PFMD_CMD_OFF) |=> (!lower_lift_drive.a_oe && !lower_lift_drive.b_oe))
      else $error("lower lift not released when off");
   lcf_rev_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_lcf == `PFMD_CMD_LH) |=> (lcf_lift_drive == 4'h7))
      else $error("feeder lift reverse pattern wrong");
   lcf_brake_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_lcf == `PFMD_CMD_BRAKE) |=> (lcf_lift_drive == 4'h3))
      else $error("feeder lift brake pattern wrong");
   fence_fwd_a : assert property (@(posedge ref_clk) disable iff (rst)
      (s_fence == `PFMD_CMD_HL) |=> (fence_drive == 4'hb))
      else $error("fence forward pattern wrong");
   tr_drive_a : assert property (@(posedge ref_clk) disable iff (rst)
      !s_tr_en_n |=> ({transport_phase_b_bar, transport_phase_a_bar, transport_phase_b, transport_phase_a}
                      == tr_phase_reg))
      else $error("transport outputs not following phase");
   tr_ramp_a : assert property (@(posedge ref_clk) disable iff (rst)
      !s_tr_mode |=> (transport_speed == pfmd_pkg::PFMD_MODE_RAMP))
      else $error("transport ramp mode wrong");
   reg_const_a : assert property (@(posedge ref_clk) disable iff (rst)
      s_reg_mode |=> (registration_speed == pfmd_pkg::PFMD_MODE_CONST))
      else $error("registration constant mode wrong");
endmodule // pfmd_drive

// ### pfmd_ctrl_model.sv
// Far-side model: feed controller reference clock and registration phases.
// Assumes the bench starts and stops it; outputs change just after ref_clk rises.
`timescale 1ns/1ps
module pfmd_ctrl_model #(
   parameter int HALF = 3
) (
   input  wire logic ref_clk,
   input  wire logic run,
   output logic      step_clk,
   output logic [3:0] phases,
   output int        rises
);
   int cnt = 0;
   initial begin
      step_clk = 1'b0;
      phases = 4'h3;
      rises = 0;
   end
   always @(posedge ref_clk) begin
      cnt <= (cnt + 1) % HALF;
      // Stops only in the low half, so a stopped clock stands low
      if (cnt == HALF - 1 && (run || step_clk)) begin
         step_clk <= ~step_clk;
      end
      if (cnt == HALF - 1 && run && !step_clk) begin
         rises <= rises + 1;
         phases <= {phases[2:0], phases[3]};
      end
   end
endmodule // pfmd_ctrl_model

// ### test_paper_feed_motor_drive_control.sv
// Self-checking bench for the paper-feed motor drive block.
// Assumes the far-side model supplies the reference clock and registration phases.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module test_paper_feed_motor_drive_control;
   typedef struct packed {logic [1:0] cmd; logic mode; logic [3:0] exp;} pfmd_tb_row_t;
   pfmd_tb_row_t rows [4] = '{'{2'b00, 1'b0, 4'h0}, '{2'b01, 1'b1, 4'h7},
                              '{2'b10, 1'b0, 4'hb}, '{2'b11, 1'b1, 4'h3}};
   logic ref_clk, rst, run, on_n, en_n, t_mode, r_mode, sclk, feed_drv, prev;
   logic [7:0] dir;
   logic [3:0] tp, rd, ph;
   pfmd_pkg::pfmd_drive_t ul, ll, lcf, fen;
   pfmd_pkg::pfmd_speed_t ts, rs, es;
   int fails = 0, comparisons = 0, rises, r0, fe;
   pfmd_ctrl_model #(.HALF(3)) u_model (.ref_clk(ref_clk), .run(run), .step_clk(sclk), .phases(ph), .rises(rises));
   pfmd_drive u_dut (.ref_clk(ref_clk), .rst(rst),
      .upper_lift_dir_a_cmd(dir[7]), .upper_lift_dir_b_cmd(dir[6]), .lower_lift_dir_a_cmd(dir[5]),
      .lower_lift_dir_b_cmd(dir[4]), .lcf_lift_dir_a_cmd(dir[3]), .lcf_lift_dir_b_cmd(dir[2]),
      .fence_dir_a_cmd(dir[1]), .fence_dir_b_cmd(dir[0]), .feed_motor_on_n(on_n), .feed_motor_ref_clock(sclk),
      .transport_ref_clock(sclk), .transport_enable_n(en_n), .transport_speed_mode(t_mode),
      .registration_phase_a(ph[3]), .registration_phase_b(ph[2]), .registration_phase_c(ph[1]),
      .registration_phase_d(ph[0]), .registration_speed_mode(r_mode), .upper_lift_drive(ul),
      .lower_lift_drive(ll), .lcf_lift_drive(lcf), .fence_drive(fen), .feed_motor_drive(feed_drv),
      .transport_phase_a(tp[0]), .transport_phase_b(tp[1]), .transport_phase_a_bar(tp[2]),
      .transport_phase_b_bar(tp[3]), .transport_speed(ts), .registration_drive(rd), .registration_speed(rs));
   function automatic logic [3:0] rot(input logic [3:0] v, input int n);
      logic [3:0] r = v;
      for (int k = 0; k < n; k++) r = {r[2:0], r[3]};
      return r;
   endfunction
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // Counts feed drive rising edges, and checks transport stays low when asked
   task automatic watch(input int n, input logic idle_low);
      fe = 0;
      repeat (n) begin
         @(negedge ref_clk);
         if (feed_drv === 1'b1 && prev === 1'b0) fe++;
         prev = feed_drv;
         if (idle_low) `CHK("transport idle", 4'h0, tp)
      end
   endtask
   task automatic test_done();
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #(25 * 4000);
      fails++;
      test_done();
   end
   initial begin
      rst = 1'b1; run = 1'b0; dir = 8'h00; on_n = 1'b1; en_n = 1'b1; t_mode = 1'b0; r_mode = 1'b0; prev = 1'b0;
      wait_cyc(3);
      `CHK("reset lift", 4'h0, ul)
      `CHK("reset transport", 4'h0, tp)
      `CHK("reset speed", pfmd_pkg::PFMD_MODE_RAMP, ts)
      wait_cyc(2);
      rst = 1'b0;
      // ****************************************
      // Bridge command and speed-mode table
      // ****************************************
      for (int i = 0; i < 4; i++) begin
         dir = {rows[i].cmd, rows[(i + 1) % 4].cmd, rows[i].cmd, rows[(i + 1) % 4].cmd};
         t_mode = rows[i].mode;
         r_mode = ~rows[i].mode;
         wait_cyc(4);
         es = rows[i].mode ? pfmd_pkg::PFMD_MODE_CONST : pfmd_pkg::PFMD_MODE_RAMP;
         `CHK("upper lift", rows[i].exp, ul)
         `CHK("lower lift", rows[(i + 1) % 4].exp, ll)
         `CHK("lcf lift", rows[i].exp, lcf)
         `CHK("fence", rows[(i + 1) % 4].exp, fen)
         `CHK("transport speed", es, ts)
         `CHK("registration speed", ~es, rs)
      end
      // ****************************************
      // Feed gate, disabled transport, stepping
      // ****************************************
      run = 1'b1;
      watch(60, 1'b1);
      `CHK("feed off", 0, fe)
      on_n = 1'b0;
      wait_cyc(6);
      r0 = rises;
      watch(60, 1'b1);
      `CHK("feed follows ref", 1'b1, (fe - (rises - r0)) inside {-1, 0, 1})
      run = 1'b0;
      on_n = 1'b1;
      wait_cyc(10);
      en_n = 1'b0;
      wait_cyc(5);
      `CHK("transport start", 4'h3, tp)
      r0 = rises;
      run = 1'b1;
      wait_cyc(33);
      run = 1'b0;
      wait_cyc(12);
      `CHK("transport steps", rot(4'h3, (rises - r0) % 4), tp)
      `CHK("registration copy", ph, rd)
      en_n = 1'b1;
      wait_cyc(5);
      `CHK("transport stop", 4'h0, tp)
      // Mid-run reset clears the registration, fence and feed drive outputs
      dir = 8'hff;
      rst = 1'b1;
      wait_cyc(2);
      `CHK("reset registration", 4'h0, rd)
      `CHK("reset fence", 4'h0, fen)
      `CHK("reset feed", 1'b0, feed_drv)
      rst = 1'b0;
      wait_cyc(4);
      `CHK("brake after reset", 4'h3, ul)
      `CHK("lcf brake after reset", 4'h3, lcf)
      test_done();
   end
endmodule // test_paper_feed_motor_drive_control
